// >>> hdl/route_mem.sv
// Small routing memory: one byte-masked write port, two registered read ports
`timescale 1ns/1ps
module route_mem #(
  parameter int               WIDTH       = 32,
  parameter int               DEPTH       = 12,
  parameter int               AW          = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               we,
  input  wire logic [AW-1:0]      waddr,
  input  wire logic [WIDTH/8-1:0] wbe,
  input  wire logic [WIDTH-1:0]   wdata,
  input  wire logic [AW-1:0]      raddr_a,
  output logic      [WIDTH-1:0]   rdata_a,
  input  wire logic [AW-1:0]      raddr_b,
  output logic      [WIDTH-1:0]   rdata_b
);

  logic [WIDTH-1:0] mem         [DEPTH];
  logic [WIDTH-1:0] next_mem    [DEPTH];
  logic [WIDTH-1:0] next_rdata_a;
  logic [WIDTH-1:0] next_rdata_b;

  always_comb begin
    next_mem = mem;
    if (we && int'(waddr) < DEPTH) begin
      for (int l = 0; l < WIDTH / 8; l++) begin
        if (wbe[l]) begin
          next_mem[waddr][8*l +: 8] = wdata[8*l +: 8];
        end
      end
    end
    next_rdata_a = (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
    next_rdata_b = (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RESET_VALUE;
      end
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      mem     <= next_mem;
      rdata_a <= next_rdata_a;
      rdata_b <= next_rdata_b;
    end
  end

endmodule

// >>> hdl/stage_input_routing_regs.sv
// Per-stage sensor input routing registers with an AXI4-Lite slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module stage_input_routing_regs
  import stage_route_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [AXI_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    conv_active,
  input  wire logic [STAGE_W-1:0]      conv_stage,
  output logic [SENSOR_COUNT-1:0]      sensor_input_pos,
  output logic [SENSOR_COUNT-1:0]      sensor_input_neg,
  output logic [SENSOR_COUNT-1:0]      sensor_input_bias,
  output logic                         neg_frontend_offset_off,
  output logic                         pos_frontend_offset_off
);

  // Address decode shared by the write and read paths
  function automatic reg_hit_s decode_addr(input logic [AXI_ADDR_W-1:0] addr);
    reg_hit_s h;
    logic [AXI_ADDR_W-1:0] idx;
    h        = '0;
    idx      = addr / STAGE_STRIDE;
    h.stage  = idx[STAGE_W-1:0];
    h.high   = (addr % STAGE_STRIDE) == ROUTE_HIGH_OFFSET;
    h.route  = (addr[1:0] == 2'h0) && (int'(idx) < STAGE_COUNT);
    h.status = (addr == STATUS_OFFSET);
    return h;
  endfunction

  // Write path state
  logic                    aw_held;
  logic                    next_aw_held;
  logic [AXI_ADDR_W-1:0]   aw_addr;
  logic [AXI_ADDR_W-1:0]   next_aw_addr;
  logic                    w_held;
  logic                    next_w_held;
  logic [REG_W-1:0]        w_data;
  logic [REG_W-1:0]        next_w_data;
  logic [1:0]              w_strb;
  logic [1:0]              next_w_strb;
  logic                    bvalid;
  logic                    next_bvalid;
  logic [1:0]              bresp;
  logic [1:0]              next_bresp;
  reg_hit_s                wr_hit;
  logic                    do_write;
  logic                    mem_we;
  logic [3:0]              mem_wbe;
  logic [2*REG_W-1:0]      mem_wdata;

  // Read path state
  reg_hit_s                ar_hit;
  rd_state_e               rd_state;
  rd_state_e               next_rd_state;
  reg_hit_s                rd_hit;
  reg_hit_s                next_rd_hit;
  logic [AXI_DATA_W-1:0]   rdata;
  logic [AXI_DATA_W-1:0]   next_rdata;
  logic [1:0]              rresp;
  logic [1:0]              next_rresp;

  // Routing pipeline state
  logic                    stage_valid;
  logic                    next_stage_valid;
  logic [STAGE_W-1:0]      stage_sel;
  logic [STAGE_W-1:0]      next_stage_sel;
  logic                    applied_active;
  logic [STAGE_W-1:0]      applied_stage;
  logic [SENSOR_COUNT-1:0] next_pos;
  logic [SENSOR_COUNT-1:0] next_neg;
  logic [SENSOR_COUNT-1:0] next_bias;
  logic                    next_neg_off;
  logic                    next_pos_off;
  logic [2*REG_W-1:0]      mem_rdata_a;
  logic [2*REG_W-1:0]      mem_rdata_b;
  logic [2*FIELD_W*LOW_INPUTS-1:0] fields;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = (rd_state == RD_IDLE);
  assign s_axi_rvalid  = (rd_state == RD_RESP);
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  assign wr_hit   = decode_addr(aw_addr);
  assign ar_hit   = decode_addr(s_axi_araddr);
  assign do_write = aw_held && w_held && !bvalid;
  assign mem_we   = do_write && wr_hit.route;
  assign mem_wbe  = wr_hit.high ? {w_strb, 2'h0} : {2'h0, w_strb};
  // Unused top bits of the low word are never stored, so they read back as zero
  assign mem_wdata = {w_data, w_data & LOW_VALID_MASK};

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[REG_W-1:0];
      next_w_strb = s_axi_wstrb[1:0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit.route ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // Read: address taken, one cycle for the registered memory port, then answer
  always_comb begin
    next_rd_state = rd_state;
    next_rd_hit   = rd_hit;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_hit   = ar_hit;
          next_rd_state = RD_WAIT;
        end
      end
      RD_WAIT: begin
        next_rresp = RESP_OKAY;
        next_rdata = '0;
        if (rd_hit.route) begin
          next_rdata[REG_W-1:0] = rd_hit.high ? mem_rdata_a[2*REG_W-1:REG_W] : mem_rdata_a[REG_W-1:0];
        end else if (rd_hit.status) begin
          next_rdata[STATUS_ACT_BIT] = applied_active;
          next_rdata[STATUS_STAGE_LO +: STAGE_W] = applied_stage;
        end else begin
          next_rresp = RESP_SLVERR;
        end
        next_rd_state = RD_RESP;
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rd_hit   <= '0;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rd_hit   <= next_rd_hit;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // One word per stage keeps both halves available to the router in one read
  route_mem #(
    .WIDTH       (2 * REG_W),
    .DEPTH       (STAGE_COUNT),
    .AW          (STAGE_W),
    .RESET_VALUE ({ROUTE_RESET, ROUTE_RESET & LOW_VALID_MASK})
  ) u_route_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we),
    .waddr   (wr_hit.stage),
    .wbe     (mem_wbe),
    .wdata   (mem_wdata),
    // Addressed straight from the bus while idle, so the word is ready by the wait state
    .raddr_a ((rd_state == RD_IDLE) ? ar_hit.stage : rd_hit.stage),
    .rdata_a (mem_rdata_a),
    .raddr_b (conv_stage),
    .rdata_b (mem_rdata_b)
  );

  // Only a converting stage with a valid number drives the switch matrix
  assign next_stage_valid = conv_active && (int'(conv_stage) < STAGE_COUNT);
  assign next_stage_sel   = conv_stage;

  // Inputs 0-6 from the low word, 7-13 from the high word, two bits each
  assign fields = {mem_rdata_b[REG_W +: 2*LOW_INPUTS], mem_rdata_b[0 +: 2*LOW_INPUTS]};

  generate
    for (genvar i = 0; i < SENSOR_COUNT; i++) begin : g_route
      always_comb begin
        next_pos[i]  = stage_valid && fields[FIELD_W*i +: FIELD_W] == ROUTE_POS;
        next_neg[i]  = stage_valid && fields[FIELD_W*i +: FIELD_W] == ROUTE_NEG;
        next_bias[i] = stage_valid && fields[FIELD_W*i +: FIELD_W] == ROUTE_BIAS;
        // Code 00 asserts none of the three, so the input floats free
      end
    end
  endgenerate

  assign next_neg_off = stage_valid && mem_rdata_b[REG_W + NEG_OFF_BIT];
  assign next_pos_off = stage_valid && mem_rdata_b[REG_W + POS_OFF_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_valid             <= 1'b0;
      stage_sel               <= '0;
      applied_active          <= 1'b0;
      applied_stage           <= '0;
      sensor_input_pos        <= '0;
      sensor_input_neg        <= '0;
      sensor_input_bias       <= '0;
      neg_frontend_offset_off <= 1'b0;
      pos_frontend_offset_off <= 1'b0;
    end else begin
      stage_valid             <= next_stage_valid;
      stage_sel               <= next_stage_sel;
      applied_active          <= stage_valid;
      applied_stage           <= stage_sel;
      sensor_input_pos        <= next_pos;
      sensor_input_neg        <= next_neg;
      sensor_input_bias       <= next_bias;
      neg_frontend_offset_off <= next_neg_off;
      pos_frontend_offset_off <= next_pos_off;
    end
  end

endmodule

// >>> hdl/stage_route_pkg.sv
// Shared constants and types for the stage input routing register bank
package stage_route_pkg;

  localparam int STAGE_COUNT  = 12;
  localparam int SENSOR_COUNT = 14;
  localparam int LOW_INPUTS   = 7;
  localparam int FIELD_W      = 2;
  localparam int REG_W        = 16;
  localparam int AXI_ADDR_W   = 12;
  localparam int AXI_DATA_W   = 32;
  localparam int STAGE_W      = 4;

  // Two-bit routing codes of one sensor input
  localparam logic [1:0] ROUTE_OPEN = 2'h0;
  localparam logic [1:0] ROUTE_NEG  = 2'h1;
  localparam logic [1:0] ROUTE_POS  = 2'h2;
  localparam logic [1:0] ROUTE_BIAS = 2'h3;

  // Byte offsets: stage n low word at n*STAGE_STRIDE, high word 4 above it
  localparam logic [11:0] ROUTE_LOW_OFFSET  = 12'h000;
  localparam logic [11:0] ROUTE_HIGH_OFFSET = 12'h004;
  localparam logic [11:0] STAGE_STRIDE      = 12'h008;
  localparam logic [11:0] STATUS_OFFSET     = 12'h060;

  // Field positions
  localparam int NEG_OFF_BIT     = 14;
  localparam int POS_OFF_BIT     = 15;
  localparam int STATUS_ACT_BIT  = 0;
  localparam int STATUS_STAGE_LO = 4;

  localparam logic [15:0] LOW_VALID_MASK = 16'h3FFF;
  localparam logic [15:0] ROUTE_RESET    = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_WAIT = 2'h1,
    RD_RESP = 2'h3
  } rd_state_e;

  typedef struct packed {
    logic               route;
    logic               status;
    logic               high;
    logic [STAGE_W-1:0] stage;
  } reg_hit_s;

endpackage

// >>> test/stage_input_routing_regs_tb_top.sv
// Self-checking bench for the stage routing register bank
`timescale 1ns/1ps
module stage_input_routing_regs_tb_top
  import stage_route_pkg::*;
  ;
  logic                    aclk, aresetn, conv_active;
  logic                    s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                    neg_frontend_offset_off, pos_frontend_offset_off;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic [2:0]              s_axi_awprot, s_axi_arprot;
  logic [STAGE_W-1:0]      conv_stage;
  logic [AXI_ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [AXI_DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
  logic [AXI_DATA_W/8-1:0] s_axi_wstrb;
  logic [SENSOR_COUNT-1:0] sensor_input_pos, sensor_input_neg, sensor_input_bias;
  logic [15:0]             lo_v [4];
  logic [15:0]             hi_v [4];
  int                      n_fail = 0;
  int                      total_checks = 0;

  stage_input_routing_regs u_stage_input_routing_regs (.*);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is judged mid-cycle so the release lands on the taking edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw;
    logic pa = 1'b1;
    logic pw = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      // Raised only once both halves are in, so a following call never drives it twice in one step
      if (!pa && !pw) s_axi_bready <= 1'b1;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk({46'h0, s_axi_bresp}, {46'h0, er});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk({14'h0, s_axi_rresp, s_axi_rdata}, {14'h0, er, 16'h0000, ed});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic route(input logic [3:0] s, input logic act, input logic [43:0] e);
    conv_active <= act;
    conv_stage  <= s;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({4'h0, sensor_input_pos, sensor_input_neg, sensor_input_bias, neg_frontend_offset_off,
         pos_frontend_offset_off}, {4'h0, e});
    @(posedge aclk);
  endtask

  function automatic logic [43:0] exp_route(input logic [15:0] lo, input logic [15:0] hi);
    logic [27:0] f;
    logic [13:0] p, n, b;
    f = {hi[13:0], lo[13:0]};
    for (int i = 0; i < 14; i++) begin
      n[i] = f[2*i+:2] == 2'h1;
      p[i] = f[2*i+:2] == 2'h2;
      b[i] = f[2*i+:2] == 2'h3;
    end
    return {p, n, b, hi[14], hi[15]};
  endfunction

  task automatic t_reset;
    rd(ROUTE_LOW_OFFSET, 16'h0000, RESP_OKAY);
    rd(12'h05C, 16'h0000, RESP_OKAY);
    route(4'h0, 1'b1, 44'h0);
  endtask

  // Each field walks through all four codes over stages 2, 5, 8 and 11
  task automatic t_fields;
    logic [27:0] f;
    logic [11:0] a;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 14; i++) f[2*i+:2] = 2'(i + k);
      lo_v[k] = {2'h3, f[13:0]};
      hi_v[k] = {2'(k), f[27:14]};
      a = 12'(24 * k + 16);
      wr(a, lo_v[k], 4'h3, RESP_OKAY);
      wr(a + 12'h004, hi_v[k], 4'h3, RESP_OKAY);
      rd(a, lo_v[k] & 16'h3FFF, RESP_OKAY);
      rd(a + 12'h004, hi_v[k], RESP_OKAY);
      route(4'(3 * k + 2), 1'b1, exp_route(lo_v[k], hi_v[k]));
    end
  endtask

  task automatic t_stages;
    route(4'h5, 1'b1, exp_route(lo_v[1], hi_v[1]));
    rd(STATUS_OFFSET, 16'h0051, RESP_OKAY);
    route(4'h3, 1'b1, 44'h0);
    route(4'hC, 1'b1, 44'h0);
    route(4'hB, 1'b0, 44'h0);
  endtask

  task automatic t_strobe;
    wr(12'h010, 16'h0055, 4'h1, RESP_OKAY);
    rd(12'h010, {lo_v[0][15:8], 8'h55} & 16'h3FFF, RESP_OKAY);
  endtask

  task automatic t_unmapped;
    wr(STATUS_OFFSET, 16'hFFFF, 4'h3, RESP_SLVERR);
    wr(12'h064, 16'hFFFF, 4'h3, RESP_SLVERR);
    wr(12'h002, 16'hFFFF, 4'h3, RESP_SLVERR);
    rd(12'h064, 16'h0000, RESP_SLVERR);
    rd(ROUTE_LOW_OFFSET, 16'h0000, RESP_OKAY);
  endtask

  initial begin
    {aresetn, conv_active, conv_stage, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_stages();
    t_strobe();
    t_unmapped();
    test_done();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    test_done();
  end
endmodule

// >>> test/stage_route_asserts.sv
// Port-level checks of the stage routing register bank
`timescale 1ns/1ps
module stage_route_asserts
  import stage_route_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    conv_active,
  input wire logic [STAGE_W-1:0]      conv_stage,
  input wire logic [SENSOR_COUNT-1:0] sensor_input_pos,
  input wire logic [SENSOR_COUNT-1:0] sensor_input_neg,
  input wire logic [SENSOR_COUNT-1:0] sensor_input_bias,
  input wire logic                    neg_frontend_offset_off,
  input wire logic                    pos_frontend_offset_off
);
  wire logic any_out = |{sensor_input_pos, sensor_input_neg, sensor_input_bias,
                         neg_frontend_offset_off, pos_frontend_offset_off};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_pos_neg; (sensor_input_pos & sensor_input_neg) == '0; endproperty
  a_pos_neg: assert property (p_pos_neg) else $error("input on both sides");
  property p_pos_bias; (sensor_input_pos & sensor_input_bias) == '0; endproperty
  a_pos_bias: assert property (p_pos_bias) else $error("positive and bias");
  property p_neg_bias; (sensor_input_neg & sensor_input_bias) == '0; endproperty
  a_neg_bias: assert property (p_neg_bias) else $error("negative and bias");
  // Outputs lag the sampled stage by two edges
  property p_idle; !$past(conv_active, 2) |-> !any_out; endproperty
  a_idle: assert property (p_idle) else $error("routing while idle");
  property p_bad_stage; $past(conv_stage, 2) >= STAGE_COUNT |-> !any_out; endproperty
  a_bad_stage: assert property (p_bad_stage) else $error("routing absent stage");
  property p_aw_hold; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_hold: assert property (p_aw_hold) else $error("address taken twice");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[1:3] s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
endmodule

bind stage_input_routing_regs stage_route_asserts u_stage_route_asserts (.*);
